// ---- verilog/uucl_regs.vh ----
// Constants for the power-up configuration loader
`ifndef UUCL_REGS_VH
`define UUCL_REGS_VH
`define UUCL_EE_ADDR_WR 8'ha0
`define UUCL_EE_ADDR_RD 8'ha1
`define UUCL_EE_NBYTES 4'h8
`define UUCL_EE_SIG_LOC 3'h7
`define UUCL_EE_VID_LO 3'h0
`define UUCL_EE_VID_HI 3'h1
`define UUCL_EE_PID_LO 3'h2
`define UUCL_EE_PID_HI 3'h3
`define UUCL_EE_ATTR 3'h4
`define UUCL_EE_PWR 3'h5
`define UUCL_ATTR_RSV7 7
`define UUCL_ATTR_SELF 6
`define UUCL_ATTR_WAKE 5
`define UUCL_ATTR_DEF 8'ha0
`define UUCL_PWR_DEF 8'h2f
`define UUCL_PKT_NORMAL 7'h40
`define UUCL_PKT_REDUCED 7'h3f
`define UUCL_ACM_FLOW 8'h01
`define UUCL_ACM_GPMODE 8'h01
`define UUCL_ACM_GPDIR 8'h08
`define UUCL_ACM_GPMASK 8'h30
`define UUCL_DEF_GPDIR 8'h00
`define UUCL_DEF_FLOW 8'h00
`define UUCL_DEF_GPMODE 8'h00
`define UUCL_DEF_GPMASK 8'h00
`define UUCL_BAUD_DEF 24'h002580
`define UUCL_DATA_BITS_DEF 4'h8
`define UUCL_NUM_CTRL_EP 2'h1
`define UUCL_NUM_CONFIG 2'h1
`define UUCL_IF_PER_CH 2'h2
// Quarter of a 100 kHz SCL bit at the 40 MHz clock
`define UUCL_QTR_CYC 16'h0064
`endif

// ---- verilog/uucl_loader.v ----
// Power-up strap and EEPROM configuration loader
`include "uucl_regs.vh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: Sample data and clock pins as straps after power-up reset.
// RULE2: Data low gives remote wakeup; clock high gives self-powered.
// RULE3: Probe EEPROM, reading eight bytes, only when both straps high.
// RULE4: Image valid only when byte seven equals the signature.
// RULE5: Failed signature discards all EEPROM data, falls back to straps.
// RULE6: EEPROM addressed with address byte 0xa0; memory must answer.
// RULE7: EEPROM holds vendor, product IDs low first, attributes, power.
// RULE8: Report default IDs unless valid image supplies its own.
// RULE9: Valid IDs replace device descriptor vendor and product fields.
// RULE10: Attributes replace bmAttributes; default 0xa0, bit6 self, bit5 wake.
// RULE11: Power byte replaces bMaxPower in 2 mA steps; default 94 mA.
// RULE12: One control endpoint, one configuration, two interfaces per channel.
// RULE13: CDC-ACM driver presets flow, pin mode, direction, event mask.
// RULE14: CDC-ACM driver gets bulk maximum packet size of 63.
// RULE15: Custom driver can select reduced packet size by register bit.
// RULE16: Custom driver: all general-purpose pins reset to inputs.
// RULE17: Channels default to 9600 bps, 8N1, no flow, independently.
// RULE18: Channel manager enables each UART with its FIFOs.
// RULE19: Lines are open drain with external pulls setting strap levels.
// RULE20: Missing acknowledge during probe invalidates image; use straps.
module uucl_loader #(
	parameter [15:0] DEF_VID = 16'h1234, // Arbitrary value
	parameter [15:0] DEF_PID = 16'h5678, // Arbitrary value
	parameter [7:0] SIG = 8'h5a // Arbitrary value
) (
	// Clock and reset
	input wire mclk_i,
	input wire rstn_i,
	input wire ce_i,
	// EEPROM pins
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	input wire scl_i,
	output wire scl_o,
	output wire scl_oe_o,
	// Driver and channel control
	input wire acm_drv_i,
	input wire [1:0] reduced_pkt_i,
	input wire [1:0] uart_en_i,
	// Descriptor fields
	output reg done_o,
	output reg valid_o,
	output reg [15:0] vid_o,
	output reg [15:0] pid_o,
	output reg [7:0] attr_o,
	output reg [7:0] max_pwr_o,
	output reg [1:0] num_ctrl_ep_o,
	output reg [1:0] num_config_o,
	output reg [1:0] if_per_ch_o,
	output reg [13:0] bulk_pkt_o,
	// Channel presets, channel B in upper half
	output reg [15:0] flow_o,
	output reg [15:0] gpio_mode_o,
	output reg [15:0] gpio_dir_o,
	output reg [15:0] gpio_mask_o,
	output reg [47:0] baud_o,
	output reg [7:0] data_bits_o,
	output reg [1:0] parity_en_o,
	output reg [1:0] stop2_o,
	output reg [1:0] uart_on_o,
	output reg [1:0] fifo_on_o
);
	localparam ST_STRAP = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_SEND = 3'h2;
	localparam ST_RSTART = 3'h3;
	localparam ST_READ = 3'h4;
	localparam ST_STOP = 3'h5;
	localparam ST_DONE = 3'h6;
	// Four of these quarters make one SCL bit
	localparam [15:0] QTR = `UUCL_QTR_CYC;

	reg sda_m, sda_s, scl_m, scl_s;
	reg [2:0] state;
	reg [15:0] tick;
	reg [1:0] phase;
	reg [3:0] bitn;
	reg [1:0] sendn;
	reg [8:0] shreg;
	reg [3:0] bytn;
	reg [7:0] img [0:7];
	reg sda_drv_low, scl_drv_low;
	reg strap_sda, strap_scl, nack, wait_cnt;
	wire qtr = (tick == QTR - 16'h0001);
	integer i;

	// RULE19: Drive low only, pulls give high
	assign sda_o = 1'b0;
	assign scl_o = 1'b0;
	assign sda_oe_o = sda_drv_low;
	assign scl_oe_o = scl_drv_low;

	// Two-stage synchronisers, reset to the pulled-up idle level
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			scl_m <= 1'b1;
			scl_s <= 1'b1;
		end else if (ce_i) begin
			sda_m <= sda_i;
			sda_s <= sda_m;
			scl_m <= scl_i;
			scl_s <= scl_m;
		end
	end

	// Bit-level sequencer: each bit is four quarter phases of SCL
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= ST_STRAP;
			tick <= 16'h0000;
			phase <= 2'h0;
			bitn <= 4'h0;
			sendn <= 2'h0;
			shreg <= 9'h000;
			bytn <= 4'h0;
			sda_drv_low <= 1'b0;
			scl_drv_low <= 1'b0;
			strap_sda <= 1'b1;
			strap_scl <= 1'b1;
			nack <= 1'b0;
			wait_cnt <= 1'b0;
			done_o <= 1'b0;
			valid_o <= 1'b0;
			for (i = 0; i < 8; i = i + 1) begin
				img[i] <= 8'h00;
			end
		end else if (ce_i) begin
			tick <= qtr ? 16'h0000 : tick + 16'h0001;
			case (state)
			ST_STRAP: begin
				// Wait for synchroniser to fill before sampling
				wait_cnt <= 1'b1;
				if (wait_cnt && qtr) begin
					// RULE1: Capture straps once
					strap_sda <= sda_s;
					strap_scl <= scl_s;
					// RULE3: Probe only with both high
					if (sda_s && scl_s) begin
						state <= ST_START;
						phase <= 2'h0;
					end else begin
						state <= ST_DONE;
					end
				end
			end
			ST_START, ST_RSTART: begin
				if (qtr) begin
					phase <= phase + 2'h1;
					case (phase)
					2'h0: begin
						sda_drv_low <= 1'b0;
						scl_drv_low <= 1'b0;
					end
					2'h1: sda_drv_low <= 1'b1;
					2'h2: scl_drv_low <= 1'b1;
					default: begin
						// RULE6: Write address, then read address
						shreg <= (state == ST_START) ?
							{`UUCL_EE_ADDR_WR, 1'b1} :
							{`UUCL_EE_ADDR_RD, 1'b1};
						bitn <= 4'h0;
						state <= ST_SEND;
					end
					endcase
				end
			end
			ST_SEND, ST_READ: begin
				if (qtr) begin
					phase <= phase + 2'h1;
					case (phase)
					2'h0: sda_drv_low <= ~shreg[8];
					2'h1: scl_drv_low <= 1'b0;
					2'h2: begin
						if (bitn == 4'h8 && state == ST_SEND) begin
							// RULE20: Missing acknowledge noted
							// A silent memory leaves the slot pulled high
							if (sda_s) begin
								nack <= 1'b1;
							end
						end
						shreg <= {shreg[7:0], sda_s};
					end
					default: begin
						scl_drv_low <= 1'b1;
						if (bitn == 4'h8) begin
							bitn <= 4'h0;
							if (state == ST_SEND) begin
								sendn <= sendn + 2'h1;
								if (nack) begin
									state <= ST_STOP;
								end else if (sendn == 2'h0) begin
									// Word address zero
									shreg <= 9'h001;
								end else if (sendn == 2'h1) begin
									state <= ST_RSTART;
								end else begin
									state <= ST_READ;
									shreg <= 9'h1ff;
								end
							end else begin
								// RULE7: Store byte at its location
								img[bytn[2:0]] <= shreg[8:1];
								bytn <= bytn + 4'h1;
								if (bytn == `UUCL_EE_NBYTES - 4'h1) begin
									state <= ST_STOP;
								end else begin
									shreg <= 9'h1ff;
								end
							end
						end else begin
							bitn <= bitn + 4'h1;
							// Acknowledge each read byte but the last
							if (state == ST_READ && bitn == 4'h7) begin
								// Keep the byte; only the ack bit is set
								shreg[8] <= (bytn ==
									`UUCL_EE_NBYTES - 4'h1);
							end else if (state == ST_SEND &&
								bitn == 4'h7) begin
								shreg <= 9'h1ff;
							end
						end
					end
					endcase
				end
			end
			ST_STOP: begin
				if (qtr) begin
					phase <= phase + 2'h1;
					case (phase)
					2'h0: sda_drv_low <= 1'b1;
					2'h1: scl_drv_low <= 1'b0;
					2'h2: sda_drv_low <= 1'b0;
					default: begin
						state <= ST_DONE;
						// RULE4: Signature check
						valid_o <= ~nack &&
							(img[`UUCL_EE_SIG_LOC] == SIG);
					end
					endcase
				end
			end
			ST_DONE: begin
				// Pulls own the bus once loading ends
				sda_drv_low <= 1'b0;
				scl_drv_low <= 1'b0;
				done_o <= 1'b1;
			end
			default: state <= ST_DONE;
			endcase
		end
	end

	// Descriptor fields follow the load result, channel presets the driver choice
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vid_o <= DEF_VID;
			pid_o <= DEF_PID;
			attr_o <= `UUCL_ATTR_DEF;
			max_pwr_o <= `UUCL_PWR_DEF;
			num_ctrl_ep_o <= `UUCL_NUM_CTRL_EP;
			num_config_o <= `UUCL_NUM_CONFIG;
			if_per_ch_o <= `UUCL_IF_PER_CH;
			bulk_pkt_o <= {`UUCL_PKT_NORMAL, `UUCL_PKT_NORMAL};
			flow_o <= {`UUCL_DEF_FLOW, `UUCL_DEF_FLOW};
			gpio_mode_o <= {`UUCL_DEF_GPMODE, `UUCL_DEF_GPMODE};
			gpio_dir_o <= {`UUCL_DEF_GPDIR, `UUCL_DEF_GPDIR};
			gpio_mask_o <= {`UUCL_DEF_GPMASK, `UUCL_DEF_GPMASK};
			baud_o <= {`UUCL_BAUD_DEF, `UUCL_BAUD_DEF};
			data_bits_o <= {`UUCL_DATA_BITS_DEF, `UUCL_DATA_BITS_DEF};
			parity_en_o <= 2'h0;
			stop2_o <= 2'h0;
			uart_on_o <= 2'h0;
			fifo_on_o <= 2'h0;
		end else if (ce_i) begin
			// RULE12: Fixed endpoint layout
			num_ctrl_ep_o <= `UUCL_NUM_CTRL_EP;
			num_config_o <= `UUCL_NUM_CONFIG;
			if_per_ch_o <= `UUCL_IF_PER_CH;
			// RULE17: Line defaults per channel
			baud_o <= {`UUCL_BAUD_DEF, `UUCL_BAUD_DEF};
			data_bits_o <= {`UUCL_DATA_BITS_DEF, `UUCL_DATA_BITS_DEF};
			parity_en_o <= 2'h0;
			stop2_o <= 2'h0;
			// RULE18: Channel manager enables
			uart_on_o <= uart_en_i;
			fifo_on_o <= uart_en_i;
			if (done_o) begin
				if (valid_o) begin
					// RULE8: Image identifiers override defaults
					// RULE9: Low byte first
					vid_o <= {img[`UUCL_EE_VID_HI], img[`UUCL_EE_VID_LO]};
					pid_o <= {img[`UUCL_EE_PID_HI], img[`UUCL_EE_PID_LO]};
					// RULE10: Attributes from image
					attr_o <= img[`UUCL_EE_ATTR];
					// RULE11: Power in 2 mA units
					max_pwr_o <= img[`UUCL_EE_PWR];
				end else begin
					// RULE5: Discard image, straps decide
					vid_o <= DEF_VID;
					pid_o <= DEF_PID;
					// RULE2: Strap decode
					attr_o <= 8'h00;
					attr_o[`UUCL_ATTR_RSV7] <= 1'b1;
					attr_o[`UUCL_ATTR_SELF] <= strap_scl;
					attr_o[`UUCL_ATTR_WAKE] <= ~strap_sda;
					max_pwr_o <= `UUCL_PWR_DEF;
				end
			end
			if (acm_drv_i) begin
				// RULE14: Reduced packet size
				bulk_pkt_o <= {`UUCL_PKT_REDUCED, `UUCL_PKT_REDUCED};
				// RULE13: CDC-ACM presets
				flow_o <= {`UUCL_ACM_FLOW, `UUCL_ACM_FLOW};
				gpio_mode_o <= {`UUCL_ACM_GPMODE, `UUCL_ACM_GPMODE};
				gpio_dir_o <= {`UUCL_ACM_GPDIR, `UUCL_ACM_GPDIR};
				gpio_mask_o <= {`UUCL_ACM_GPMASK, `UUCL_ACM_GPMASK};
			end else begin
				// RULE15: Custom driver selects size
				bulk_pkt_o[6:0] <= reduced_pkt_i[0] ?
					`UUCL_PKT_REDUCED : `UUCL_PKT_NORMAL;
				bulk_pkt_o[13:7] <= reduced_pkt_i[1] ?
					`UUCL_PKT_REDUCED : `UUCL_PKT_NORMAL;
				// RULE16: Pins are inputs
				flow_o <= {`UUCL_DEF_FLOW, `UUCL_DEF_FLOW};
				gpio_mode_o <= {`UUCL_DEF_GPMODE, `UUCL_DEF_GPMODE};
				gpio_dir_o <= {`UUCL_DEF_GPDIR, `UUCL_DEF_GPDIR};
				gpio_mask_o <= {`UUCL_DEF_GPMASK, `UUCL_DEF_GPMASK};
			end
		end
	end
endmodule
`default_nettype wire

// ---- test/uucl_loader_props.sv ----
// Port checker for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module uucl_loader_props #(
	parameter [15:0] DEF_VID = 16'h1234,
	parameter [15:0] DEF_PID = 16'h5678
) (
	// Clock, reset and controls
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic acm_drv_i,
	input wire logic [1:0] reduced_pkt_i,
	input wire logic [1:0] uart_en_i,
	// Observed outputs
	input wire logic sda_o,
	input wire logic scl_o,
	input wire logic done_o,
	input wire logic valid_o,
	input wire logic [15:0] vid_o,
	input wire logic [15:0] pid_o,
	input wire logic [7:0] attr_o,
	input wire logic [7:0] max_pwr_o,
	input wire logic [1:0] num_ctrl_ep_o,
	input wire logic [1:0] num_config_o,
	input wire logic [1:0] if_per_ch_o,
	input wire logic [13:0] bulk_pkt_o,
	input wire logic [15:0] flow_o,
	input wire logic [15:0] gpio_dir_o,
	input wire logic [1:0] uart_on_o,
	input wire logic [1:0] fifo_on_o
);
default clocking cb @(posedge mclk_i); endclocking
default disable iff (!rstn_i);
// Registered outputs need the driver choice held for two edges
sequence s_acm; acm_drv_i [*2]; endsequence
sequence s_custom; (!acm_drv_i && $stable(reduced_pkt_i)) [*2]; endsequence
sequence s_fallback; done_o && $past(done_o) ##0 !valid_o; endsequence
a_pins_low: assert property (sda_o == 1'b0 && scl_o == 1'b0)
	else $error("pin data not zero");
a_usb_layout: assert property (num_ctrl_ep_o == 2'h1
	&& num_config_o == 2'h1 && if_per_ch_o == 2'h2)
	else $error("usb layout wrong");
a_acm_preset: assert property (s_acm |-> flow_o == 16'h0101
	&& gpio_dir_o == 16'h0808 && bulk_pkt_o == {7'h3f, 7'h3f})
	else $error("cdc presets wrong");
a_custom_pkt: assert property (s_custom |-> gpio_dir_o == 16'h0
	&& bulk_pkt_o[6:0] == (reduced_pkt_i[0] ? 7'h3f : 7'h40))
	else $error("custom packet size wrong");
a_uart_follow: assert property (uart_on_o == $past(uart_en_i)
	&& fifo_on_o == $past(uart_en_i))
	else $error("uart enable not followed");
a_done_hold: assert property (done_o |=> done_o && $stable(valid_o))
	else $error("load result moved");
a_default_ids: assert property (s_fallback |-> vid_o == DEF_VID
	&& pid_o == DEF_PID)
	else $error("default ids wrong");
a_fallback_fld: assert property (s_fallback |-> max_pwr_o == 8'h2f
	&& attr_o[7] && attr_o[4:0] == 5'h0)
	else $error("fallback fields wrong");
endmodule
`default_nettype wire

// ---- test/uucl_ee_model.sv ----
// Serial EEPROM model on the open-drain pair
`timescale 1ns/1ps
`default_nettype none
module uucl_ee_model (
	// Bus lines and setup
	input wire logic scl,
	input wire logic sda,
	input wire logic fitted,
	input wire logic deaf,
	input wire logic [63:0] img,
	// High pulls data low
	output logic pull
);
logic act = 0, rd = 0, sel = 0;
logic [3:0] cnt, nb;
logic [7:0] sh;
logic [2:0] ptr = 0;
initial pull = 0;
// Start and stop reset the byte framing
always @(sda) if (scl && fitted) begin
	act = !sda; cnt = 0; nb = 0; rd = 0; pull = 0;
end
always @(posedge scl) if (act) begin
	if (cnt < 8) sh = {sh[6:0], sda};
	else if (rd && nb > 0 && sda) act = 0;
	if (cnt == 8) begin
		cnt = 0;
		if (rd && nb > 0) ptr = ptr + 1;
		nb = nb + 1;
	end else cnt = cnt + 1;
end
// ack only at 0xa0 or 0xa1 (device 0x50), otherwise line left to pull-up
always @(negedge scl) if (act) begin
	if (cnt == 8) begin
		if (nb == 0) begin
			sel = sh[7:1] == 7'h50 && !deaf;
			rd = sh[0];
		end else if (!rd) ptr = sh[2:0];
		pull = sel && !(rd && nb > 0);
	// byte ptr of the image, bit 7 first
	end else pull = sel && rd && nb > 0 && !img[{ptr, ~cnt[2:0]}];
end
endmodule
`default_nettype wire

// ---- test/uucl_loader_test.sv ----
// Testbench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module uucl_loader_test;
localparam logic [15:0] VID0 = 16'h1357; // Arbitrary value
localparam logic [15:0] PID0 = 16'h2468; // Arbitrary value
localparam logic [7:0] SIG0 = 8'h3c; // Arbitrary value
localparam logic [63:0] IMG = {SIG0, 56'hab19809c42beef};
logic mclk_i = 0, rstn_i = 0, acm_drv_i = 0, ee_on = 0, deaf = 0, oe = 0;
logic sda_lvl = 1, scl_lvl = 1, ce = 1;
logic [1:0] reduced_pkt_i = 0, uart_en_i = 0;
logic [63:0] img = 0;
wire logic sda_o, scl_o, sda_oe_o, scl_oe_o, pull, done_o, valid_o;
wire logic [15:0] vid_o, pid_o, flow_o, gpio_mode_o, gpio_dir_o, gpio_mask_o;
wire logic [7:0] attr_o, max_pwr_o, data_bits_o;
wire logic [1:0] num_ctrl_ep_o, num_config_o, if_per_ch_o, parity_en_o;
wire logic [1:0] stop2_o, uart_on_o, fifo_on_o;
wire logic [13:0] bulk_pkt_o;
wire logic [47:0] baud_o;
wire logic sda_w = (sda_oe_o || pull) ? 1'b0 : sda_lvl;
wire logic scl_w = scl_oe_o ? 1'b0 : scl_lvl;
int n_fail = 0, tests_run = 0;
uucl_loader #(.DEF_VID(VID0), .DEF_PID(PID0), .SIG(SIG0)) dut (.mclk_i,
	.rstn_i, .ce_i(ce), .sda_i(sda_w), .sda_o, .sda_oe_o, .scl_i(scl_w),
	.scl_o, .scl_oe_o, .acm_drv_i, .reduced_pkt_i, .uart_en_i, .done_o,
	.valid_o, .vid_o, .pid_o, .attr_o, .max_pwr_o, .num_ctrl_ep_o,
	.num_config_o, .if_per_ch_o, .bulk_pkt_o, .flow_o, .gpio_mode_o,
	.gpio_dir_o, .gpio_mask_o, .baud_o, .data_bits_o, .parity_en_o,
	.stop2_o, .uart_on_o, .fifo_on_o);
uucl_ee_model ee (.scl(scl_w), .sda(sda_w), .fitted(ee_on), .deaf(deaf),
	.img(img), .pull(pull));
initial forever #12.5 mclk_i = ~mclk_i;
task chk(input logic [47:0] got, input logic [47:0] exp);
	tests_run++;
	if (got !== exp) begin
		n_fail++;
		$display("BAD %0t got %h want %h", $time, got, exp);
	end
endtask
task report_and_stop;
	$display("compares %0d mismatches %0d", tests_run, n_fail);
	if (n_fail == 0 && tests_run > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
// Straps are set by the pulls while reset holds
task boot(input logic s, c, on, nk, input logic [63:0] im);
	int i;
	@(posedge mclk_i);
	rstn_i <= 0; sda_lvl <= s; scl_lvl <= c; ee_on <= on;
	deaf <= nk; img <= im; oe = 0;
	repeat (8) @(posedge mclk_i);
	rstn_i <= 1;
	for (i = 0; i < 45000 && done_o !== 1'b1; i++) begin
		@(posedge mclk_i);
		oe = oe | sda_oe_o | scl_oe_o;
	end
	if (done_o !== 1'b1) begin
		$display("BAD %0t load timed out", $time);
		n_fail++;
		report_and_stop;
	end else begin
		repeat (3) @(posedge mclk_i);
		#1;
	end
endtask
task t_straps;
	int k;
	for (k = 0; k < 4; k++) begin
		boot(k[1], k[0], 0, 0, 0);
		chk(oe, k == 3);
		chk(valid_o, 0);
		chk(attr_o, {1'b1, k[0], !k[1], 5'h0});
		chk({vid_o, pid_o, max_pwr_o}, {VID0, PID0, 8'h2f});
	end
	$display("strap test finished");
endtask
// Clock enable low after release must hold the loader still
task t_freeze;
	@(posedge mclk_i);
	rstn_i <= 0; ce <= 0; sda_lvl <= 0; scl_lvl <= 0; ee_on <= 0;
	repeat (8) @(posedge mclk_i);
	rstn_i <= 1;
	repeat (300) @(posedge mclk_i);
	#1;
	chk(done_o, 0);
	@(posedge mclk_i);
	ce <= 1;
	repeat (300) @(posedge mclk_i);
	#1;
	chk(done_o, 1);
	chk(attr_o, 8'ha0);
	$display("freeze test finished");
endtask
task t_image;
	boot(1, 1, 1, 0, IMG);
	chk(valid_o, 1);
	chk({vid_o, pid_o}, 32'hbeef9c42);
	chk({attr_o, max_pwr_o}, 16'h8019);
	$display("image test finished");
endtask
// Bad signature or silent memory both fall back to straps
task t_fail(input logic nk, input logic [63:0] im);
	boot(1, 1, 1, nk, im);
	chk(valid_o, 0);
	chk({vid_o, pid_o, attr_o, max_pwr_o}, {VID0, PID0, 16'hc02f});
	$display("fallback test finished");
endtask
task t_drv;
	@(posedge mclk_i);
	acm_drv_i <= 1; uart_en_i <= 2'b10;
	repeat (3) @(posedge mclk_i);
	#1;
	chk({flow_o, gpio_mode_o, gpio_dir_o}, 48'h010101010808);
	chk(gpio_mask_o, 16'h3030);
	chk(bulk_pkt_o, {7'h3f, 7'h3f});
	chk({uart_on_o, fifo_on_o}, 4'ha);
	@(posedge mclk_i);
	acm_drv_i <= 0; reduced_pkt_i <= 2'b01; uart_en_i <= 2'b01;
	repeat (3) @(posedge mclk_i);
	#1;
	chk(bulk_pkt_o, {7'h40, 7'h3f});
	chk(gpio_dir_o, 16'h0);
	chk({uart_on_o, fifo_on_o}, 4'h5);
	chk(baud_o, {2{24'h002580}});
	chk({data_bits_o, parity_en_o, stop2_o}, 12'h880);
	chk({num_ctrl_ep_o, num_config_o, if_per_ch_o}, 6'h16);
	$display("driver test finished");
endtask
initial begin
	t_straps;
	t_freeze;
	t_image;
	t_fail(0, IMG ^ {8'h01, 56'h0});
	t_fail(1, IMG);
	t_drv;
	report_and_stop;
end
endmodule
bind uucl_loader uucl_loader_props #(.DEF_VID(DEF_VID), .DEF_PID(DEF_PID))
	u_props (.mclk_i, .rstn_i, .acm_drv_i, .reduced_pkt_i, .uart_en_i,
	.sda_o, .scl_o, .done_o, .valid_o, .vid_o, .pid_o, .attr_o, .max_pwr_o,
	.num_ctrl_ep_o, .num_config_o, .if_per_ch_o, .bulk_pkt_o, .flow_o,
	.gpio_dir_o, .uart_on_o, .fifo_on_o);
`default_nettype wire
